// File: swc_switch_core.sv
// Switch forwarding core: ingress queues, egress arbitration, replay buffers
`timescale 1ns/10ps
module swc_switch_core (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                rx_valid        [swc_pkg::NP],
    input  wire swc_pkg::pkt_type    rx_pkt          [swc_pkg::NP],
    output logic                     rx_ready        [swc_pkg::NP],
    output swc_pkg::cnt_type         rx_credit       [swc_pkg::NP][swc_pkg::NVC],
    output logic                     rx_drop         [swc_pkg::NP],
    output logic                     tx_valid        [swc_pkg::NP],
    output swc_pkg::pkt_type         tx_pkt          [swc_pkg::NP],
    input  wire logic                tx_ready        [swc_pkg::NP],
    input  wire logic                tx_ack          [swc_pkg::NP],
    input  wire logic                tx_replay       [swc_pkg::NP],
    input  wire swc_pkg::id_type     port_id         [swc_pkg::NP],
    input  wire swc_pkg::addr_type   mem_base        [swc_pkg::NP],
    input  wire swc_pkg::addr_type   mem_limit       [swc_pkg::NP],
    input  wire swc_pkg::tcmap_type  tc_vc_map       [swc_pkg::NP],
    input  wire logic                vc1_en,
    input  wire logic                p2p_redirect_en,
    input  wire logic                xlat_direct_en
);
    import swc_pkg::*;

    // Ingress state
    ptr_type         in_wr_q    [NP][NVC];
    ptr_type         in_wr_d    [NP][NVC];
    ptr_type         in_rd_q    [NP][NVC];
    ptr_type         in_rd_d    [NP][NVC];
    logic            in_fresh_q [NP][NVC];
    logic            in_fresh_d [NP][NVC];
    cnt_type         credit_q   [NP][NVC];
    cnt_type         credit_d   [NP][NVC];
    logic            drop_q     [NP];
    logic            drop_d     [NP];
    tok_type         tok_q      [NP];
    tok_type         tok_d      [NP];
    logic [WINW-1:0] win_q;
    logic [WINW-1:0] win_d;
    logic            win_end;
    cnt_type         cap;
    cnt_type         in_cnt     [NP][NVC];
    logic            head_ok    [NP][NVC];
    entry_type       head       [NP][NVC];
    route_type       rt         [NP];
    logic            rx_vc      [NP];
    logic            push       [NP];
    logic            pop        [NP][NVC];
    logic            q_wen      [NP];
    logic [AW-1:0]   q_waddr    [NP];
    logic [AW-1:0]   q_raddr    [NP][NVC];

    // Egress state
    ptr_type         rp_wr_q    [NP];
    ptr_type         rp_wr_d    [NP];
    ptr_type         rp_send_q  [NP];
    ptr_type         rp_send_d  [NP];
    ptr_type         rp_ack_q   [NP];
    ptr_type         rp_ack_d   [NP];
    logic            rp_fresh_q [NP];
    logic            rp_fresh_d [NP];
    port_type        rr_q       [NP][NVC];
    port_type        rr_d       [NP][NVC];
    logic            gnt        [NP][NP][NVC];
    logic            gnt_vc1    [NP];
    logic            any_vc1    [NP];
    logic            rp_room    [NP];
    logic            rp_wen     [NP];
    entry_type       rp_wdata   [NP];

    // Queue address; VC1 half is lent to VC0 when VC1 is off
    function automatic logic [AW-1:0] q_addr(
        input logic    vc,
        input ptr_type ptr,
        input logic    split
    );
        return split ? {vc, ptr[AW-2:0]} : ptr[AW-1:0];
    endfunction : q_addr

    // Round robin pick starting after the last winner
    function automatic logic [PORTW:0] rr_pick(
        input logic [NP-1:0] req,
        input port_type      last
    );
        logic [PORTW:0] res;
        port_type       idx;
        res = '0;
        idx = '0;
        for (int n = NP; n >= 1; n--) begin
            idx = port_type'((int'(last) + n) % NP);
            if (req[idx]) begin
                res = {1'h1, idx};
            end
        end
        return res;
    endfunction : rr_pick

    // Destination by ID or address window, then peer access control
    function automatic route_type route_pkt(
        input pkt_type  p,
        input port_type src,
        input id_type   ids   [NP],
        input addr_type base  [NP],
        input addr_type limit [NP],
        input logic     redir,
        input logic     direct
    );
        route_type r;
        logic      hit;
        r   = '{ok: 1'h0, dest: port_type'(UP_PORT)};
        hit = 1'h0;
        for (int n = 1; n < NP; n++) begin
            if (p.id_routed ? (p.dest_id == ids[n])
                            : (p.addr >= base[n] && p.addr <= limit[n])) begin
                hit    = 1'h1;
                r.dest = port_type'(n);
            end
        end
        if (hit && src != port_type'(UP_PORT) && redir && p.kind != KIND_CPL
            && !(p.xlat && direct)) begin
            r.dest = port_type'(UP_PORT);
        end
        r.ok = (hit || src != port_type'(UP_PORT)) && r.dest != src;
        return r;
    endfunction : route_pkt

    assign cap = vc1_en ? cnt_type'(QD_SPLIT) : cnt_type'(QD_SHARE);

    // Ingress next state
    always_comb begin
        win_end = (win_q == WINW'(ISO_WIN_CYC - 1));
        win_d   = win_end ? '0 : win_q + 1'h1;
        for (int i = 0; i < NP; i++) begin
            rt[i]       = route_pkt(rx_pkt[i], port_type'(i), port_id, mem_base,
                                    mem_limit, p2p_redirect_en, xlat_direct_en);
            rx_vc[i]    = vc1_en && rx_pkt[i].tc != 3'(TC_DEFAULT)
                          && tc_vc_map[i][rx_pkt[i].tc];
            rx_ready[i] = in_cnt[i][rx_vc[i]] < cap;
            push[i]     = rx_valid[i] && rx_ready[i];
            q_wen[i]    = push[i] && rt[i].ok;
            q_waddr[i]  = q_addr(rx_vc[i], in_wr_q[i][rx_vc[i]], vc1_en);
            drop_d[i]   = push[i] && !rt[i].ok;
            tok_d[i]    = win_end ? TOKW'(ISO_CREDITS)
                                  : tok_q[i] - TOKW'(pop[i][1]);
            for (int v = 0; v < NVC; v++) begin
                in_wr_d[i][v]    = in_wr_q[i][v] + PW'(q_wen[i] && rx_vc[i] == 1'(v));
                in_rd_d[i][v]    = in_rd_q[i][v] + PW'(pop[i][v]);
                q_raddr[i][v]    = q_addr(1'(v), in_rd_d[i][v], vc1_en);
                in_fresh_d[i][v] = q_wen[i] && rx_vc[i] == 1'(v)
                                   && in_wr_q[i][v] == in_rd_d[i][v];
                credit_d[i][v]   = (v == 1 && !vc1_en) ? '0
                                   : cap - (in_wr_d[i][v] - in_rd_d[i][v]);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            win_q <= '0;
            for (int i = 0; i < NP; i++) begin
                drop_q[i] <= 1'h0;
                tok_q[i]  <= TOKW'(ISO_CREDITS);
                for (int v = 0; v < NVC; v++) begin
                    in_wr_q[i][v]    <= '0;
                    in_rd_q[i][v]    <= '0;
                    in_fresh_q[i][v] <= 1'h0;
                    credit_q[i][v]   <= '0;
                end
            end
        end else if (ce) begin
            win_q      <= win_d;
            drop_q     <= drop_d;
            tok_q      <= tok_d;
            in_wr_q    <= in_wr_d;
            in_rd_q    <= in_rd_d;
            in_fresh_q <= in_fresh_d;
            credit_q   <= credit_d;
        end
    end

    // Dedicated input queue memory per ingress port
    for (genvar i = 0; i < NP; i++) begin : g_inq
        swc_mem_if #(.NRD(NVC)) qif ();
        swc_qmem #(.NRD(NVC)) u_qmem (
            .clk (core_clk),
            .rst (rst),
            .ce  (ce),
            .m   (qif.mem)
        );
        assign qif.wr_en   = q_wen[i];
        assign qif.wr_addr = q_waddr[i];
        assign qif.wr_data = '{dest: rt[i].dest, pkt: rx_pkt[i]};
        for (genvar v = 0; v < NVC; v++) begin : g_vc
            assign qif.rd_addr[v] = q_raddr[i][v];
            assign head[i][v]     = qif.rd_data[v];
            assign in_cnt[i][v]   = in_wr_q[i][v] - in_rd_q[i][v];
            assign head_ok[i][v]  = in_cnt[i][v] != '0 && !in_fresh_q[i][v];
        end
    end

    // Egress arbitration and replay pointers
    always_comb begin
        logic [NP-1:0]  rq [NVC];
        logic [PORTW:0] pk;
        logic           v1;
        rq = '{default: '0};
        pk = '0;
        v1 = 1'h0;
        for (int e = 0; e < NP; e++) begin
            rp_room[e] = (rp_wr_q[e] - rp_ack_q[e]) != PW'(RP_DEPTH);
            for (int i = 0; i < NP; i++) begin
                for (int v = 0; v < NVC; v++) begin
                    gnt[e][i][v] = 1'h0;
                    rq[v][i]     = head_ok[i][v] && head[i][v].dest == port_type'(e)
                                   && (v == 0 || tok_q[i] != '0);
                end
            end
            v1          = |rq[1];
            any_vc1[e]  = v1;
            pk          = rr_pick(rq[v1], rr_q[e][v1]);
            rr_d[e]     = rr_q[e];
            rp_wen[e]   = rp_room[e] && pk[PORTW];
            rp_wdata[e] = head[pk[PORTW-1:0]][v1];
            if (rp_wen[e]) begin
                gnt[e][pk[PORTW-1:0]][v1] = 1'h1;
                rr_d[e][v1]               = pk[PORTW-1:0];
            end
            gnt_vc1[e]    = rp_wen[e] && v1;
            rp_ack_d[e]   = rp_ack_q[e] + PW'(tx_ack[e] && rp_ack_q[e] != rp_send_q[e]);
            tx_valid[e]   = rp_send_q[e] != rp_wr_q[e] && !rp_fresh_q[e];
            rp_send_d[e]  = tx_replay[e] ? rp_ack_d[e]
                            : rp_send_q[e] + PW'(tx_valid[e] && tx_ready[e]);
            rp_wr_d[e]    = rp_wr_q[e] + PW'(rp_wen[e]);
            rp_fresh_d[e] = rp_wen[e] && rp_wr_q[e] == rp_send_d[e];
        end
        for (int i = 0; i < NP; i++) begin
            for (int v = 0; v < NVC; v++) begin
                pop[i][v] = 1'h0;
                for (int e = 0; e < NP; e++) begin
                    pop[i][v] = pop[i][v] | gnt[e][i][v];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int e = 0; e < NP; e++) begin
                rp_wr_q[e]    <= '0;
                rp_send_q[e]  <= '0;
                rp_ack_q[e]   <= '0;
                rp_fresh_q[e] <= 1'h0;
                rr_q[e]       <= '{default: '0};
            end
        end else if (ce) begin
            rp_wr_q    <= rp_wr_d;
            rp_send_q  <= rp_send_d;
            rp_ack_q   <= rp_ack_d;
            rp_fresh_q <= rp_fresh_d;
            rr_q       <= rr_d;
        end
    end

    // Replay buffer memory per egress port
    for (genvar e = 0; e < NP; e++) begin : g_rpq
        swc_mem_if #(.NRD(1)) rif ();
        swc_qmem #(.NRD(1)) u_rpmem (
            .clk (core_clk),
            .rst (rst),
            .ce  (ce),
            .m   (rif.mem)
        );
        assign rif.wr_en      = rp_wen[e];
        assign rif.wr_addr    = rp_wr_q[e][AW-1:0];
        assign rif.wr_data    = rp_wdata[e];
        assign rif.rd_addr[0] = rp_send_d[e][AW-1:0];
        assign tx_pkt[e]      = rif.rd_data[0].pkt;
    end

    assign rx_drop   = drop_q;
    assign rx_credit = credit_q;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || !ce);

    for (genvar e = 0; e < NP; e++) begin : g_chk_out
        a_tx_hold_whole: assert property (
            tx_valid[e] && !tx_ready[e] && !tx_replay[e]
            |=> tx_valid[e] && $stable(tx_pkt[e]))
            else $error("Stalled egress packet changed");
        a_vc1_first: assert property (
            any_vc1[e] && rp_room[e] |-> gnt_vc1[e])
            else $error("VC0 granted while VC1 waited");
        a_replay_rewind: assert property (
            tx_replay[e] && !tx_ack[e] |=> rp_send_q[e] == $past(rp_ack_q[e]))
            else $error("Replay did not rewind to oldest unacked");
        a_replay_bound: assert property (
            rp_wen[e] |-> (rp_wr_q[e] - rp_ack_q[e]) < PW'(RP_DEPTH))
            else $error("Replay buffer overfilled");
    end

    for (genvar i = 0; i < NP; i++) begin : g_chk_in
        a_iso_police: assert property (
            pop[i][1] && !win_end |=> tok_q[i] == $past(tok_q[i]) - 1'h1)
            else $error("Isochronous credit not charged");
        a_tc0_vc0: assert property (
            push[i] && rx_pkt[i].tc == 3'(TC_DEFAULT) |-> !rx_vc[i])
            else $error("Default class left VC0");
        a_fifo_step: assert property (
            pop[i][0] |=> in_rd_q[i][0] == $past(in_rd_q[i][0]) + 1'h1)
            else $error("Queue head skipped");
        a_credit_own: assert property (
            1'h1 |=> credit_q[i][0] == cnt_type'($past(cap) - in_cnt[i][0]))
            else $error("Advertised credit mismatch");
        a_share_room: assert property (
            !vc1_en && in_cnt[i][0] < cnt_type'(QD_SHARE) |-> rx_ready[i])
            else $error("Lent VC1 storage not used");
        a_acs_redirect: assert property (
            push[i] && rt[i].ok && i != UP_PORT && p2p_redirect_en
            && rx_pkt[i].kind != KIND_CPL && !(rx_pkt[i].xlat && xlat_direct_en)
            |-> rt[i].dest == port_type'(UP_PORT))
            else $error("Peer request not redirected");
    end

    c_both_dirs: cover property (tx_valid[0] && tx_ready[0] && tx_valid[1] && tx_ready[1]);
    c_vc1_grant: cover property (gnt_vc1[1] && head_ok[2][0]);
    c_replay: cover property (tx_replay[0] && tx_valid[0]);
    c_share_full: cover property (!vc1_en && in_cnt[1][0] == cnt_type'(QD_SHARE));
endmodule : swc_switch_core

// File: swc_pkg.sv
// Shared constants and types for the switch forwarding core
package swc_pkg;
    localparam int NP         = 6;
    localparam int NVC        = 2;
    localparam int NTC        = 8;
    localparam int PORTW      = 3;
    localparam int AW         = 4;
    localparam int PW         = AW + 1;
    localparam int MEM_DEPTH  = 1 << AW;
    localparam int QD_SPLIT   = 8;
    localparam int QD_SHARE   = 16;
    localparam int RP_DEPTH   = 16;
    localparam int UP_PORT    = 0;
    localparam int TC_DEFAULT = 0;
    localparam int CLK_MHZ    = 200;
    localparam int ISO_WIN_NS = 1000;
    localparam int ISO_WIN_CYC = ISO_WIN_NS * CLK_MHZ / 1000;
    localparam int ISO_CREDITS = 4;
    localparam int TOKW       = 3;
    localparam int WINW       = 8;

    typedef logic [PORTW-1:0] port_type;
    typedef logic [PW-1:0]    ptr_type;
    typedef logic [PW-1:0]    cnt_type;
    typedef logic [TOKW-1:0]  tok_type;
    typedef logic [NTC-1:0]   tcmap_type;
    typedef logic [15:0]      id_type;
    typedef logic [31:0]      addr_type;

    typedef enum logic [1:0] {KIND_POSTED, KIND_NONPOSTED, KIND_CPL} kind_type;

    typedef struct packed {
        kind_type    kind;
        logic [2:0]  tc;
        logic        id_routed;
        logic        xlat;
        id_type      req_id;
        id_type      cpl_id;
        id_type      dest_id;
        addr_type    addr;
        logic [31:0] payload;
    } pkt_type;

    typedef struct packed {
        port_type dest;
        pkt_type  pkt;
    } entry_type;

    typedef struct packed {
        logic     ok;
        port_type dest;
    } route_type;
endpackage : swc_pkg

// File: swc_mem_if.sv
// Port bundle between a queue owner and its queue memory
`timescale 1ns/10ps
interface swc_mem_if #(
    parameter int NRD = 2
);
    import swc_pkg::*;
    logic              wr_en;
    logic [AW-1:0]     wr_addr;
    entry_type         wr_data;
    logic [AW-1:0]     rd_addr [NRD];
    entry_type         rd_data [NRD];
    modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : swc_mem_if

// File: swc_qmem.sv
// Queue memory with one write port and registered read ports
`timescale 1ns/10ps
module swc_qmem #(
    parameter int NRD = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    swc_mem_if.mem   m
);
    import swc_pkg::*;

    entry_type mem_q [MEM_DEPTH];
    entry_type rd_q  [NRD];
    entry_type rd_d  [NRD];

    always_comb begin
        for (int r = 0; r < NRD; r++) begin
            rd_d[r] = mem_q[m.rd_addr[r]];
        end
    end

    always_ff @(posedge clk) begin
        if (ce && m.wr_en) begin
            mem_q[m.wr_addr] <= m.wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < NRD; r++) begin
                rd_q[r] <= '0;
            end
        end else if (ce) begin
            rd_q <= rd_d;
        end
    end

    assign m.rd_data = rd_q;
endmodule : swc_qmem

// File: swc_link_model.sv
// Link partner model standing at the egress side of every switch port
`timescale 1ns/10ps
module swc_link_model (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              tx_valid   [swc_pkg::NP],
    input  wire swc_pkg::pkt_type  tx_pkt     [swc_pkg::NP],
    output logic                   tx_ready   [swc_pkg::NP],
    output logic                   tx_ack     [swc_pkg::NP],
    output logic                   tx_replay  [swc_pkg::NP],
    input  wire logic              stall      [swc_pkg::NP],
    input  wire logic              hold_ack,
    input  wire logic              replay_req [swc_pkg::NP]
);
    import swc_pkg::*;
    pkt_type got_q     [NP][$];
    logic    take_ok   [NP];
    logic    ack_d     [NP];
    int      unacked_q [NP];

    // Stall gives a slow partner; a replay request is passed straight through to tx_replay
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            tx_ready[p]  = !stall[p];
            tx_replay[p] = replay_req[p];
            ack_d[p]     = !hold_ack && (unacked_q[p] != 0);
            take_ok[p]   = (tx_valid[p] === 1'b1) && tx_ready[p] && !tx_replay[p];
        end
    end

    // A packet is taken at the rising edge where valid and ready stand together and tx_replay is low
    always @(posedge core_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (!rst && take_ok[p]) begin
                got_q[p].push_back(tx_pkt[p]);
            end
        end
    end

    // One acknowledge for each received packet, held back while asked to
    always_ff @(posedge core_clk or posedge rst) begin
        for (int p = 0; p < NP; p++) begin
            if (rst) begin
                unacked_q[p] <= 0;
                tx_ack[p]    <= 1'b0;
            end else begin
                unacked_q[p] <= unacked_q[p] + int'(take_ok[p]) - int'(ack_d[p]);
                tx_ack[p]    <= ack_d[p];
            end
        end
    end
endmodule : swc_link_model

// File: testbench.sv
// Self-checking testbench for the switch forwarding core
`timescale 1ns/10ps
module testbench;
    import swc_pkg::*;
    typedef struct {
        int src; kind_type kind; int idr; int xl; int tc; logic [31:0] tgt;
        int redir; int direct; int exp;
    } swc_row_type;
    logic      core_clk, rst, ce, vc1_en, p2p_redirect_en, xlat_direct_en, hold_ack;
    logic      rx_valid [NP], rx_ready [NP], rx_drop [NP], stall [NP], replay_req [NP];
    logic      tx_valid [NP], tx_ready [NP], tx_ack [NP], tx_replay [NP];
    pkt_type   rx_pkt [NP], tx_pkt [NP], pk;
    cnt_type   rx_credit [NP][NVC];
    id_type    port_id [NP];
    addr_type  mem_base [NP], mem_limit [NP];
    tcmap_type tc_vc_map [NP];
    int        err_count, n_compared;
    swc_row_type rows [9] = '{
        '{0, KIND_POSTED,    0, 0, 0, 32'h0300_0010, 0, 0, 3},
        '{0, KIND_NONPOSTED, 1, 0, 0, 32'h0000_0105, 0, 0, 5},
        '{2, KIND_CPL,       1, 0, 0, 32'h0000_0100, 0, 0, 0},
        '{2, KIND_POSTED,    0, 0, 0, 32'h7000_0000, 0, 0, 0},
        '{1, KIND_POSTED,    0, 0, 0, 32'h0400_0000, 0, 0, 4},
        '{1, KIND_NONPOSTED, 0, 0, 0, 32'h0400_0000, 1, 0, 0},
        '{1, KIND_POSTED,    0, 1, 0, 32'h0400_0000, 1, 1, 4},
        '{4, KIND_POSTED,    0, 0, 5, 32'h0100_0000, 0, 0, 1},
        '{5, KIND_CPL,       1, 0, 0, 32'h0000_0103, 1, 0, 3}};

    swc_switch_core uut (.core_clk(core_clk), .rst(rst), .ce(ce), .rx_valid(rx_valid),
        .rx_pkt(rx_pkt), .rx_ready(rx_ready), .rx_credit(rx_credit), .rx_drop(rx_drop),
        .tx_valid(tx_valid), .tx_pkt(tx_pkt), .tx_ready(tx_ready), .tx_ack(tx_ack),
        .tx_replay(tx_replay), .port_id(port_id), .mem_base(mem_base),
        .mem_limit(mem_limit), .tc_vc_map(tc_vc_map), .vc1_en(vc1_en),
        .p2p_redirect_en(p2p_redirect_en), .xlat_direct_en(xlat_direct_en));
    swc_link_model link (.core_clk(core_clk), .rst(rst), .tx_valid(tx_valid),
        .tx_pkt(tx_pkt), .tx_ready(tx_ready), .tx_ack(tx_ack), .tx_replay(tx_replay),
        .stall(stall), .hold_ack(hold_ack), .replay_req(replay_req));

    always #2.5 core_clk = ~core_clk;

    function automatic pkt_type mk(input int i, input kind_type k, input int idr,
                                   input int xl, input int tc, input logic [31:0] tgt);
        pkt_type p;
        p = '0;
        p.kind = k;
        p.tc = 3'(tc);
        p.id_routed = idr[0];
        p.xlat = xl[0];
        p.req_id = 16'hA000 + 16'(i);
        p.cpl_id = 16'h5A00 + 16'(i);
        p.dest_id = tgt[15:0];
        p.addr = tgt;
        p.payload = 32'hC0DE_0000 + 32'(i);
        return p;
    endfunction : mk

    task automatic check(input logic [$bits(pkt_type)-1:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check

    // Offer one packet and hold it until the edge that takes it
    task automatic send(input int src, input pkt_type p);
        int n;
        n = 0;
        @(posedge core_clk);
        #1 rx_pkt[src] = p;
        rx_valid[src] = 1'b1;
        @(negedge core_clk);
        while (rx_ready[src] !== 1'b1 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        if (n == 100) begin
            err_count++;
            $display("CHECK FAILED at %0t: ingress %0d never ready", $time, src);
        end
        @(posedge core_clk);
        #1 rx_valid[src] = 1'b0;
    endtask : send

    task automatic expect_pkt(input int port, input pkt_type exp);
        int n;
        n = 0;
        while (link.got_q[port].size() == 0 && n < 80) begin
            @(posedge core_clk);
            #1 n++;
        end
        if (link.got_q[port].size() == 0) begin
            err_count++;
            $display("CHECK FAILED at %0t: no packet on port %0d", $time, port);
        end else begin
            check(link.got_q[port].pop_front(), exp, "egress packet differs");
        end
    endtask : expect_pkt

    task automatic check_credits(input int c0, input int c1);
        for (int p = 0; p < NP; p++) begin
            check(rx_credit[p][0], c0, "VC0 credit");
            check(rx_credit[p][1], c1, "VC1 credit");
        end
    endtask : check_credits

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        #50_000;
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        {core_clk, ce, rst, vc1_en, hold_ack} = 5'h0E;
        {p2p_redirect_en, xlat_direct_en, err_count, n_compared} = '0;
        for (int p = 0; p < NP; p++) begin
            {rx_valid[p], stall[p], replay_req[p], rx_pkt[p]} = '0;
            port_id[p] = 16'h0100 + 16'(p);
            mem_base[p] = 32'(p) << 24;
            mem_limit[p] = (32'(p) << 24) + 32'h00FF_FFFF;
            tc_vc_map[p] = 8'hFE;
        end
        repeat (5) @(posedge core_clk);
        check(rx_credit[1][0], 0, "credit during reset");
        check(tx_valid[0], 1'b0, "egress idle during reset");
        check(rx_ready[1], 1'b1, "ingress ready during reset");
        check(rx_drop[0], 1'b0, "no drop during reset");
        #1 rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check_credits(8, 8);
        $display("test reset done");
        foreach (rows[i]) begin
            p2p_redirect_en = rows[i].redir[0];
            xlat_direct_en = rows[i].direct[0];
            pk = mk(i, rows[i].kind, rows[i].idr, rows[i].xl, rows[i].tc, rows[i].tgt);
            send(rows[i].src, pk);
            expect_pkt(rows[i].exp, pk);
        end
        {p2p_redirect_en, xlat_direct_en} = 2'h0;
        $display("test routing table done");
        fork
            send(0, mk(20, KIND_NONPOSTED, 0, 0, 0, 32'h0200_0000));
            send(3, mk(21, KIND_CPL, 1, 0, 0, 32'h0000_0100));
        join
        expect_pkt(2, mk(20, KIND_NONPOSTED, 0, 0, 0, 32'h0200_0000));
        expect_pkt(0, mk(21, KIND_CPL, 1, 0, 0, 32'h0000_0100));
        $display("test both directions done");
        fork
            send(2, mk(25, KIND_POSTED, 0, 0, 0, 32'h0100_0000));
            send(4, mk(26, KIND_POSTED, 0, 0, 5, 32'h0100_0000));
        join
        expect_pkt(1, mk(26, KIND_POSTED, 0, 0, 5, 32'h0100_0000));
        expect_pkt(1, mk(25, KIND_POSTED, 0, 0, 0, 32'h0100_0000));
        $display("test channel priority done");
        stall[0] = 1'b1;
        for (int k = 0; k < 3; k++) send(5, mk(30 + k, KIND_POSTED, 0, 0, 0, 32'h7000_0000));
        repeat (10) @(posedge core_clk);
        #1 stall[0] = 1'b0;
        for (int k = 0; k < 3; k++) begin
            expect_pkt(0, mk(30 + k, KIND_POSTED, 0, 0, 0, 32'h7000_0000));
        end
        $display("test ordering under stall done");
        send(0, mk(40, KIND_POSTED, 0, 0, 0, 32'h7000_0000));
        check(rx_drop[0], 1'b1, "unroutable from upstream kept");
        send(2, mk(41, KIND_POSTED, 0, 0, 0, 32'h0200_0000));
        check(rx_drop[2], 1'b1, "packet back to its source kept");
        $display("test drops done");
        hold_ack = 1'b1;
        pk = mk(50, KIND_POSTED, 0, 0, 0, 32'h7000_0000);
        send(3, pk);
        expect_pkt(0, pk);
        @(posedge core_clk);
        #1 replay_req[0] = 1'b1;
        @(posedge core_clk);
        #1 replay_req[0] = 1'b0;
        expect_pkt(0, pk);
        hold_ack = 1'b0;
        repeat (10) @(posedge core_clk);
        $display("test replay done");
        #1 vc1_en = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check_credits(16, 0);
        $display("test shared storage done");
        final_report();
    end
endmodule : testbench
